// ==== hw/pbm_pkg.sv ====
package pbm_pkg;

	// function selection per pin group
	typedef enum logic [1:0] {
		PBM_FN_GPIO = 2'h0,
		PBM_FN_FCC  = 2'h1,
		PBM_FN_SCC  = 2'h2,
		PBM_FN_TDM  = 2'h3
	} pbm_fn_e;

	// fast controller sub-mode
	typedef enum logic [0:0] {
		PBM_FAST_MII  = 1'h0,
		PBM_FAST_HDLC = 1'h1
	} pbm_fast_e;

	// word carried through the receive buffer
	typedef struct packed {
		logic rx_dv;
		logic rx_er;
		logic crs;
		logic broken_hdr;
		logic scc_rxd;
		logic tdm_rxd;
		logic tdm_rsync;
		logic tdm_tsync;
	} pbm_rx_s;

	localparam int PBM_RX_W    = 8;
	localparam int PBM_PINS    = 4;
	localparam int PBM_BUF_DEP = 2;

	// pin positions inside the upper nibble
	localparam int PBM_PIN28 = 0;
	localparam int PBM_PIN29 = 1;
	localparam int PBM_PIN30 = 2;
	localparam int PBM_PIN31 = 3;

	localparam logic [3:0] PBM_OE_N_RST = 4'hf;
	localparam logic [3:0] PBM_DO_RST   = 4'h0;

endpackage : pbm_pkg

// ==== hw/pbm_buf.sv ====
`timescale 1ns/1ns
module pbm_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	// write side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// read side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	if (DEPTH != 2 || WIDTH < 1) begin : g_bad_cfg
		$error("pbm_buf serves only a two-entry buffer");
	end

	logic             skid_valid;
	logic [WIDTH-1:0] skid_data;
	logic             push;
	logic             pop;
	logic             next_skid_valid;

	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	// head word feeds the reader; skid word catches a push during a stall,
	// so a reader that keeps ready high sees one word per cycle
	always_comb begin
		next_skid_valid = skid_valid;
		if (!out_valid_out || pop) begin
			next_skid_valid = skid_valid && push;
		end else if (push) begin
			next_skid_valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!out_valid_out || pop) begin
			out_data_out <= skid_valid ? skid_data : in_data_in;
		end
		if (push && (skid_valid || (out_valid_out && !pop))) begin
			skid_data <= in_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			skid_valid    <= 1'b0;
			in_ready_out  <= 1'b1;
		end else begin
			if (!out_valid_out || pop) begin
				out_valid_out <= skid_valid || push;
			end
			skid_valid   <= next_skid_valid;
			in_ready_out <= !next_skid_valid;
		end
	end
endmodule : pbm_buf

// ==== hw/pbm_mux.sv ====
`timescale 1ns/1ns
module pbm_mux (
	// clock and reset
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_n_in,
	// function selection
	input  wire pbm_pkg::pbm_fn_e     fn_sel_in,
	input  wire pbm_pkg::pbm_fast_e   fast_mode_in,
	input  wire logic                 scc_ether_in,
	// general purpose side
	input  wire logic [3:0]           gpio_do_in,
	input  wire logic [3:0]           gpio_dir_in,
	output logic      [3:0]           gpio_di_out,
	// fast controller side
	input  wire logic                 fast_tx_er_in,
	input  wire logic                 fast_tx_en_in,
	input  wire logic                 fast_rts_req_in,
	input  wire logic                 fast_cts_n_in,
	output logic                      fast_granted_out,
	input  wire logic                 fast_crs_in,
	// serial controller side
	input  wire logic                 scc_txd_in,
	input  wire logic                 scc_rts_req_in,
	input  wire logic                 scc_cts_n_in,
	output logic                      scc_granted_out,
	// tdm channel side
	input  wire logic                 tdm_txd_in,
	// receive stream to peripherals
	output logic                      rx_valid_out,
	input  wire logic                 rx_ready_in,
	output pbm_pkg::pbm_rx_s          rx_data_out,
	output logic                      rx_overrun_out,
	// pins 28..31
	input  wire logic [3:0]           pin_in,
	output logic      [3:0]           pin_out,
	output logic      [3:0]           pin_oe_n_out
);
	logic [3:0]        pin_meta;
	logic [3:0]        pin_sync;
	logic [1:0]        fcts_meta;
	logic [1:0]        scts_meta;
	logic              fcts_n;
	logic              scts_n;
	logic [3:0]        next_do;
	logic [3:0]        next_oe_n;
	pbm_pkg::pbm_rx_s  rx_word;
	logic              buf_ready;
	logic              buf_valid;
	pbm_pkg::pbm_rx_s  buf_data;

	// two-stage capture of pins and clear inputs
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta  <= 4'h0;
			pin_sync  <= 4'h0;
			fcts_meta <= 2'h3;
			scts_meta <= 2'h3;
		end else begin
			pin_meta  <= pin_in;
			pin_sync  <= pin_meta;
			fcts_meta <= {fcts_meta[0], fast_cts_n_in};
			scts_meta <= {scts_meta[0], scc_cts_n_in};
		end
	end
	assign fcts_n = fcts_meta[1];
	assign scts_n = scts_meta[1];

	// pin drive and direction per selected function
	always_comb begin
		next_do   = 4'h0;
		next_oe_n = pbm_pkg::PBM_OE_N_RST;
		case (fn_sel_in)
			pbm_pkg::PBM_FN_GPIO: begin
				next_do   = gpio_do_in;
				next_oe_n = ~gpio_dir_in;
			end
			pbm_pkg::PBM_FN_FCC: begin
				if (fast_mode_in == pbm_pkg::PBM_FAST_MII) begin
					next_do[pbm_pkg::PBM_PIN31]   = fast_tx_er_in;
					next_oe_n[pbm_pkg::PBM_PIN31] = 1'b0;
					next_do[pbm_pkg::PBM_PIN29]   = fast_tx_en_in;
					next_oe_n[pbm_pkg::PBM_PIN29] = 1'b0;
				end else begin
					// request driven at once, no bit alignment
					next_do[pbm_pkg::PBM_PIN28]   = ~fast_rts_req_in;
					next_oe_n[pbm_pkg::PBM_PIN28] = 1'b0;
				end
			end
			pbm_pkg::PBM_FN_SCC: begin
				next_do[pbm_pkg::PBM_PIN30]   = scc_txd_in;
				next_oe_n[pbm_pkg::PBM_PIN30] = 1'b0;
				// ethernet: active-high enable; else active-low request
				next_do[pbm_pkg::PBM_PIN28]   = scc_ether_in ? scc_rts_req_in
				                                             : ~scc_rts_req_in;
				next_oe_n[pbm_pkg::PBM_PIN28] = 1'b0;
			end
			pbm_pkg::PBM_FN_TDM: begin
				next_do[pbm_pkg::PBM_PIN31]   = tdm_txd_in;
				next_oe_n[pbm_pkg::PBM_PIN31] = 1'b0;
			end
			default: begin
				next_do   = 4'h0;
				next_oe_n = pbm_pkg::PBM_OE_N_RST;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_out      <= pbm_pkg::PBM_DO_RST;
			pin_oe_n_out <= pbm_pkg::PBM_OE_N_RST;
		end else begin
			pin_out      <= next_do;
			pin_oe_n_out <= next_oe_n;
		end
	end

	// grants and general purpose read back
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fast_granted_out <= 1'b0;
			scc_granted_out  <= 1'b0;
			gpio_di_out      <= 4'h0;
		end else begin
			fast_granted_out <= (fn_sel_in == pbm_pkg::PBM_FN_FCC)
			                    && (fast_mode_in == pbm_pkg::PBM_FAST_HDLC)
			                    && fast_rts_req_in && !fcts_n;
			scc_granted_out  <= (fn_sel_in == pbm_pkg::PBM_FN_SCC)
			                    && !scc_ether_in && scc_rts_req_in && !scts_n;
			gpio_di_out      <= pin_sync;
		end
	end

	// receive word: inputs only for the selected function
	always_comb begin
		rx_word = '0;
		case (fn_sel_in)
			pbm_pkg::PBM_FN_FCC: begin
				if (fast_mode_in == pbm_pkg::PBM_FAST_MII) begin
					rx_word.rx_dv      = pin_sync[pbm_pkg::PBM_PIN30];
					rx_word.rx_er      = pin_sync[pbm_pkg::PBM_PIN28];
					rx_word.crs        = fast_crs_in;
					rx_word.broken_hdr = fast_crs_in && !pin_sync[pbm_pkg::PBM_PIN30];
				end
			end
			pbm_pkg::PBM_FN_SCC: begin
				rx_word.scc_rxd = pin_sync[pbm_pkg::PBM_PIN31];
			end
			pbm_pkg::PBM_FN_TDM: begin
				rx_word.tdm_rxd   = pin_sync[pbm_pkg::PBM_PIN30];
				rx_word.tdm_rsync = pin_sync[pbm_pkg::PBM_PIN29];
				rx_word.tdm_tsync = pin_sync[pbm_pkg::PBM_PIN28];
			end
			default: begin
				rx_word = '0;
			end
		endcase
	end

	pbm_buf #(
		.WIDTH(pbm_pkg::PBM_RX_W),
		.DEPTH(pbm_pkg::PBM_BUF_DEP)
	) u_buf (
		.sys_clk_in   (sys_clk_in),
		.rst_n_in     (rst_n_in),
		.in_valid_in  (fn_sel_in != pbm_pkg::PBM_FN_GPIO),
		.in_ready_out (buf_ready),
		.in_data_in   (rx_word),
		.out_valid_out(buf_valid),
		.out_ready_in (rx_ready_in),
		.out_data_out (buf_data)
	);

	// stream outputs; overrun sticks until reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_overrun_out <= 1'b0;
		end else if ((fn_sel_in != pbm_pkg::PBM_FN_GPIO) && !buf_ready) begin
			rx_overrun_out <= 1'b1;
		end
	end
	assign rx_valid_out = buf_valid;
	assign rx_data_out  = buf_data;
endmodule : pbm_mux

// ==== bench/pbm_mux_monitor.sv ====
`timescale 1ns/1ns
module pbm_mux_monitor (
	// clock and reset
	input wire logic	sys_clk_in,
	input wire logic	rst_n_in,
	// selection and peripheral side
	input wire pbm_pkg::pbm_fn_e	fn_sel_in,
	input wire pbm_pkg::pbm_fast_e	fast_mode_in,
	input wire logic	scc_ether_in,
	input wire logic	fast_tx_er_in,
	input wire logic	fast_tx_en_in,
	input wire logic	fast_rts_req_in,
	input wire logic	fast_cts_n_in,
	input wire logic	fast_granted_out,
	input wire logic	scc_txd_in,
	input wire logic	scc_rts_req_in,
	input wire logic	scc_cts_n_in,
	input wire logic	scc_granted_out,
	input wire logic	tdm_txd_in,
	// stream and pins
	input wire logic	rx_valid_out,
	input wire pbm_pkg::pbm_rx_s	rx_data_out,
	input wire logic	rx_overrun_out,
	input wire logic [3:0]	pin_out,
	input wire logic [3:0]	pin_oe_n_out
);
	wire fcc = fn_sel_in == pbm_pkg::PBM_FN_FCC;
	wire mii = fcc && fast_mode_in == pbm_pkg::PBM_FAST_MII;
	wire hdlc = fcc && fast_mode_in == pbm_pkg::PBM_FAST_HDLC;
	wire scc = fn_sel_in == pbm_pkg::PBM_FN_SCC;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_mii_tx_error: assert property (mii |=> !pin_oe_n_out[3]
		&& pin_out[3] == $past(fast_tx_er_in)) else $error("bad tx error pin");
	a_mii_tx_enable: assert property (mii |=> pin_oe_n_out == 4'h5
		&& pin_out[1] == $past(fast_tx_en_in)) else $error("bad tx enable pin");
	a_hdlc_request: assert property (hdlc |=> pin_oe_n_out == 4'he
		&& pin_out[0] == !$past(fast_rts_req_in)) else $error("bad fast request");
	a_fast_grant: assert property ((hdlc && fast_rts_req_in && !fast_cts_n_in)[*4]
		|-> fast_granted_out) else $error("fast grant late");
	a_fast_hold: assert property (fast_cts_n_in[*4] |-> !fast_granted_out)
		else $error("fast grant early");
	a_scc_grant: assert property ((scc && !scc_ether_in && scc_rts_req_in
		&& !scc_cts_n_in)[*4] |-> scc_granted_out) else $error("serial grant late");
	a_scc_request: assert property (scc |=> !pin_oe_n_out[0]
		&& pin_out[0] == ($past(scc_rts_req_in) ~^ $past(scc_ether_in))) else $error("bad req");
	a_scc_data: assert property (scc |=> pin_oe_n_out == 4'ha
		&& pin_out[2] == $past(scc_txd_in)) else $error("bad serial pins");
	a_tdm_pins: assert property (fn_sel_in == pbm_pkg::PBM_FN_TDM |=>
		pin_oe_n_out == 4'h7 && pin_out[3] == $past(tdm_txd_in)) else $error("bad tdm pins");
	a_broken_header: assert property (rx_valid_out && rx_data_out.broken_hdr |->
		rx_data_out.crs && !rx_data_out.rx_dv) else $error("bad broken header");
	c_mii: cover property (mii ##1 fast_tx_en_in);
	c_grant: cover property ($rose(fast_granted_out));
	c_overrun: cover property ($rose(rx_overrun_out));
endmodule : pbm_mux_monitor
bind pbm_mux pbm_mux_monitor u_mon (.*);

// ==== bench/pbm_far_model.sv ====
`timescale 1ns/1ns
module pbm_far_model (
	// clock and mode
	input wire logic	sys_clk_in,
	input wire pbm_pkg::pbm_fn_e	fn_in,
	input wire logic	hdlc_in,
	input wire logic	slow_in,
	// pins
	input wire logic [3:0]	pin_out_in,
	input wire logic [3:0]	pin_oe_n_in,
	input wire logic [3:0]	stim_in,
	output logic [3:0]	wire_out,
	output logic	cts_n_out
);
	logic [3:0]	drv;
	logic [3:0]	rts_dly = 4'hf;
	logic	tog = 1'h0;
	always_comb begin
		case (fn_in)
			pbm_pkg::PBM_FN_FCC: drv = hdlc_in ? 4'h0 : 4'h5;
			pbm_pkg::PBM_FN_SCC: drv = 4'h8;
			pbm_pkg::PBM_FN_TDM: drv = 4'h7;
			default: drv = 4'hf;
		endcase
	end
	// undriven lines toggle, no stale level
	assign wire_out = (~pin_oe_n_in & pin_out_in)
		| (pin_oe_n_in & ((drv & stim_in) | (~drv & {4{tog}})));
	always @(posedge sys_clk_in) begin
		tog <= ~tog;
		rts_dly <= {rts_dly[2:0], wire_out[0]};
	end
	assign cts_n_out = slow_in ? rts_dly[3] : rts_dly[0];
endmodule : pbm_far_model

// ==== bench/pbm_mux_tb.sv ====
`timescale 1ns/1ns
module pbm_mux_tb;
	pbm_pkg::pbm_fn_e	fn_sel_in = pbm_pkg::PBM_FN_GPIO;
	pbm_pkg::pbm_fast_e	fast_mode_in = pbm_pkg::PBM_FAST_MII;
	logic	sys_clk_in = 1'h0, rst_n_in = 1'h0, scc_ether_in = 1'h0, slow = 1'h0;
	logic	fast_tx_er_in = 1'h0, fast_tx_en_in = 1'h0, fast_rts_req_in = 1'h0;
	logic	fast_crs_in = 1'h0, scc_txd_in = 1'h0, scc_rts_req_in = 1'h0;
	logic	tdm_txd_in = 1'h0, rx_ready_in = 1'h1, cts_n, fast_cts_n_in, scc_cts_n_in;
	logic	fast_granted_out, scc_granted_out, rx_valid_out, rx_overrun_out;
	logic [3:0]	gpio_do_in = 4'h0, gpio_dir_in = 4'h0, stim = 4'h0;
	logic [3:0]	gpio_di_out, pin_in, pin_out, pin_oe_n_out;
	pbm_pkg::pbm_rx_s	rx_data_out;
	int	num_errors = 0;
	int	n_checks = 0;
	assign fast_cts_n_in = cts_n;
	assign scc_cts_n_in = cts_n;
	always #4 sys_clk_in = ~sys_clk_in;
	pbm_mux DUT (.*);
	pbm_far_model u_far (.sys_clk_in, .fn_in(fn_sel_in), .hdlc_in(fast_mode_in), .slow_in(slow),
		.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n_out), .stim_in(stim), .wire_out(pin_in),
		.cts_n_out(cts_n));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task cy(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : cy
	task end_sim;
		if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task t_gpio;
		{gpio_dir_in, gpio_do_in, stim} = {4'h5, 4'hf, 4'h8};
		cy(6);
		chk({pin_oe_n_out, gpio_di_out}, 8'had);
	endtask : t_gpio
	task t_mii;
		fn_sel_in = pbm_pkg::PBM_FN_FCC;
		{fast_tx_er_in, fast_crs_in, stim} = {2'h3, 4'h1};
		cy(6);
		chk({pin_oe_n_out, pin_out[3], pin_out[1]}, 8'h16);
		chk({rx_data_out.rx_dv, rx_data_out.rx_er, rx_data_out.broken_hdr}, 8'h3);
		{fast_tx_er_in, fast_tx_en_in, stim} = {2'h1, 4'h4};
		cy(6);
		chk({pin_out[3], pin_out[1]}, 8'h1);
		chk({rx_data_out.rx_dv, rx_data_out.rx_er, rx_data_out.broken_hdr}, 8'h4);
	endtask : t_mii
	task t_hdlc;
		fast_mode_in = pbm_pkg::PBM_FAST_HDLC;
		{slow, fast_rts_req_in} = 2'h3;
		cy(12);
		chk({pin_oe_n_out, pin_out[0], fast_granted_out}, 8'h39);
		fast_rts_req_in = 1'h0;
		cy(12);
		chk({pin_out[0], fast_granted_out}, 8'h2);
	endtask : t_hdlc
	task t_scc;
		fn_sel_in = pbm_pkg::PBM_FN_SCC;
		{slow, scc_rts_req_in, scc_txd_in, stim} = {3'h3, 4'h8};
		cy(10);
		chk({pin_oe_n_out, pin_out[2], pin_out[0], scc_granted_out}, 8'h55);
		chk(rx_data_out.scc_rxd, 8'h1);
		scc_ether_in = 1'h1;
		cy(10);
		chk({pin_out[0], scc_granted_out}, 8'h2);
	endtask : t_scc
	task t_tdm;
		fn_sel_in = pbm_pkg::PBM_FN_TDM;
		{tdm_txd_in, stim} = {1'h1, 4'h5};
		cy(6);
		chk({pin_oe_n_out, pin_out[3]}, 8'hf);
		chk({rx_data_out.tdm_rxd, rx_data_out[1:0]}, 8'h5);
		stim = 4'h2;
		cy(6);
		chk({rx_data_out.tdm_rxd, rx_data_out[1:0]}, 8'h2);
		chk({rx_valid_out, rx_overrun_out}, 8'h2);
		rx_ready_in = 1'h0;
		cy(6);
		chk({rx_valid_out, rx_overrun_out}, 8'h3);
		fn_sel_in = pbm_pkg::PBM_FN_GPIO;
		rx_ready_in = 1'h1;
		cy(6);
		chk({rx_valid_out, rx_overrun_out}, 8'h1);
	endtask : t_tdm
	initial begin
		cy(10);
		rst_n_in = 1'h1;
		cy(2);
		t_gpio;
		t_mii;
		t_hdlc;
		t_scc;
		t_tdm;
		end_sim;
	end
	initial begin
		#20000;
		num_errors++;
		end_sim;
	end
endmodule : pbm_mux_tb
